//--- design/bwp_regs_top.sv
// Burst wrap / drive configuration, correction status and protection mode
// registers, reached by decoded serial register commands.
// Assumes an outer serial front end that frames each command into one
// cmd_valid_i pulse with opcode, address and data, synchronous to mclk_i.
//
// Function
// [RL1] Wrap bit 0 wraps, 1 reads sequentially
// [RL2] Span field selects 8/16/32/64 byte wrap
// [RL3] Burst config via any-register and set-burst
// [RL4] Drive strength writable at any time
// [RL5] Correction read returns selected unit status
// [RL6] Bit 2 flags corrected check-code error
// [RL7] Bit 1 flags corrected data error
// [RL8] Bit 0 flags correction disabled
// [RL9] Status read-only, reset to zero
// [RL10] Host ignores upper five status bits
// [RL11] Protection mode is 16-bit one-time field
// [RL12] Protection mode via dedicated and any-register
// [RL13] Secret lock zero selects password mode
// [RL14] Persistent lock zero selects persistent mode
// [RL15] Reset reloads burst config from copy
// [RL16] Wrap affects only quad reads
// [RL17] Program only while both locks one
// [RL18] Programming both locks zero fails
// [RL19] Host writes reserved bits as zero
`timescale 1ns/1ps
`default_nettype none
`include "bwp_regs.svh"

module bwp_regs_top #(
    parameter int UNITS = 16,
    parameter int UNIT_W = 4
) (
    input wire logic mclk_i,                // 200 MHz clock
    input wire logic rst_i,                 // Hw/sw reset, sync high
    input wire logic por_i,                 // Power-on, sync high
    input wire logic [7:0] boot_cfg_i,      // Burst boot config copy
    input wire logic cmd_valid_i,           // Command pulse
    input wire logic [7:0] cmd_op_i,        // Command opcode
    input wire logic [23:0] cmd_addr_i,     // Register or unit address
    input wire logic [15:0] cmd_data_i,     // Write data
    input wire logic quad_read_i,           // Quad I/O read active
    input wire logic ddr_quad_read_i,       // DDR quad I/O read active
    input wire logic corr_upd_i,            // Engine status update
    input wire logic [UNIT_W-1:0] corr_unit_i, // Updated unit
    input wire logic [2:0] corr_flags_i,    // Updated flags
    input wire logic prog_err_clr_i,        // Clear program error
    output logic rsp_valid_o,               // Read answer pulse
    output logic [15:0] rsp_data_o,         // Read answer data
    output logic [7:0] burst_cfg_o,         // Burst config register
    output logic [2:0] drive_strength_o,    // Output drive select
    output logic wrap_active_o,             // Wrapped burst in force
    output logic [6:0] wrap_bytes_o,        // Wrap span in bytes
    output logic [15:0] prot_mode_o,        // Protection mode register
    output logic secret_mode_o,             // Password mode selected
    output logic persist_mode_o,            // Persistent mode selected
    output logic prog_err_o                 // Program error flag
);

    bwp_pkg::bwp_cmd_t cmd;
    logic [7:0] cfg_reg, cfg_next;
    logic [15:0] prot_reg, prot_next;
    logic secret_reg, secret_next, persist_reg, persist_next;
    logic perr_reg, perr_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [15:0] rsp_data_reg, rsp_data_next;
    logic wrap_act_reg, wrap_act_next;
    logic [6:0] wrap_bytes_reg, wrap_bytes_next;
    logic [2:0] corr_flags;
    logic hit_cfg, hit_prot, pgm_req, pgm_ok;
    logic [15:0] pgm_data;

    // ==========================================================
    // Correction status table
    bwp_corr_table #(
        .UNITS(UNITS),
        .UNIT_W(UNIT_W)
    ) u_corr (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .upd_valid_i(corr_upd_i),
        .upd_unit_i(corr_unit_i),
        .upd_flags_i(corr_flags_i),
        .rd_unit_i(cmd_addr_i[UNIT_W-1:0]),
        .rd_flags_o(corr_flags)
    );

    // ==========================================================
    // Command decode
    always_comb begin
        cmd = bwp_pkg::BWP_CMD_NONE;
        if (cmd_valid_i) begin
            case (cmd_op_i)
                `BWP_OP_ANY_RD: cmd = bwp_pkg::BWP_CMD_ANY_RD;
                `BWP_OP_ANY_WR: cmd = bwp_pkg::BWP_CMD_ANY_WR;
                `BWP_OP_SET_BURST: cmd = bwp_pkg::BWP_CMD_SET_BURST;
                `BWP_OP_CORR_RD_A: cmd = bwp_pkg::BWP_CMD_CORR_RD;
                `BWP_OP_CORR_RD_B: cmd = bwp_pkg::BWP_CMD_CORR_RD;
                `BWP_OP_PROT_RD: cmd = bwp_pkg::BWP_CMD_PROT_RD;
                `BWP_OP_PROT_PGM: cmd = bwp_pkg::BWP_CMD_PROT_PGM;
                default: cmd = bwp_pkg::BWP_CMD_NONE;
            endcase
        end
    end

    assign hit_cfg = (cmd_addr_i == `BWP_ADDR_BURST_CFG);
    assign hit_prot = (cmd_addr_i == `BWP_ADDR_PROT_MODE);

    // ==========================================================
    // Burst configuration register
    always_comb begin
        cfg_next = cfg_reg;
        if (rst_i) begin
            cfg_next = boot_cfg_i & `BWP_CFG_WR_MASK; // RL15
        end else if (cmd == bwp_pkg::BWP_CMD_SET_BURST ||
                     (cmd == bwp_pkg::BWP_CMD_ANY_WR && hit_cfg)) begin
            // Reserved bits are stored as zero
            cfg_next = cmd_data_i[7:0] & `BWP_CFG_WR_MASK; // RL3 RL4 RL19
        end
        wrap_bytes_next = `BWP_WRAP_BASE <<
            cfg_next[`BWP_CFG_SPAN_HI:`BWP_CFG_SPAN_LO]; // RL2
        wrap_act_next = !cfg_reg[`BWP_CFG_WRAP_DIS] &&
            (quad_read_i || ddr_quad_read_i); // RL1 RL16
        if (rst_i) begin
            wrap_act_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        cfg_reg <= cfg_next;
        wrap_bytes_reg <= wrap_bytes_next;
        wrap_act_reg <= wrap_act_next;
    end

    // ==========================================================
    // Protection mode register, one-time programmable
    assign pgm_req = (cmd == bwp_pkg::BWP_CMD_PROT_PGM) ||
                     (cmd == bwp_pkg::BWP_CMD_ANY_WR && hit_prot); // RL12
    assign pgm_data = cmd_data_i;
    assign pgm_ok = (prot_reg[2:1] == `BWP_PROT_OPEN) &&
                    (pgm_data[2:1] != `BWP_PROT_BOTH); // RL17 RL18

    always_comb begin
        prot_next = prot_reg;
        perr_next = perr_reg;
        if (prog_err_clr_i) begin
            perr_next = 1'b0;
        end
        if (pgm_req) begin
            if (pgm_ok) begin
                // Bits only move from one to zero
                prot_next = prot_reg & pgm_data; // RL11
            end else begin
                perr_next = 1'b1; // RL17 RL18
            end
        end
        secret_next = !prot_next[`BWP_PROT_SECRET_LOCK]; // RL13
        persist_next = !prot_next[`BWP_PROT_PERSIST_LOCK]; // RL14
    end

    // Only power-on touches the one-time field; other resets keep it
    always_ff @(posedge mclk_i) begin
        if (por_i) begin
            prot_reg <= `BWP_PROT_FACTORY;
            secret_reg <= 1'b0;
            persist_reg <= 1'b0;
        end else begin
            prot_reg <= prot_next;
            secret_reg <= secret_next;
            persist_reg <= persist_next;
        end
        if (rst_i || por_i) begin
            perr_reg <= 1'b0;
        end else begin
            perr_reg <= perr_next;
        end
    end

    // ==========================================================
    // Read answers
    always_comb begin
        rsp_valid_next = 1'b0;
        rsp_data_next = rsp_data_reg;
        case (cmd)
            bwp_pkg::BWP_CMD_ANY_RD: begin
                rsp_valid_next = 1'b1;
                if (hit_cfg) begin
                    rsp_data_next = {8'h00, cfg_reg}; // RL3
                end else if (hit_prot) begin
                    rsp_data_next = prot_reg; // RL12
                end else begin
                    rsp_data_next = 16'h0000;
                end
            end
            bwp_pkg::BWP_CMD_CORR_RD: begin
                rsp_valid_next = 1'b1;
                // Upper status bits are returned as zero
                rsp_data_next = {13'h0000, corr_flags}; // RL5 RL10
            end
            bwp_pkg::BWP_CMD_PROT_RD: begin
                rsp_valid_next = 1'b1;
                rsp_data_next = prot_reg; // RL12
            end
            default: begin
                rsp_valid_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= 16'h0000;
        end else begin
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg <= rsp_data_next;
        end
    end

    // ==========================================================
    // Outputs
    assign rsp_valid_o = rsp_valid_reg;
    assign rsp_data_o = rsp_data_reg;
    assign burst_cfg_o = cfg_reg;
    assign drive_strength_o = cfg_reg[`BWP_CFG_DRIVE_HI:`BWP_CFG_DRIVE_LO];
    assign wrap_active_o = wrap_act_reg;
    assign wrap_bytes_o = wrap_bytes_reg;
    assign prot_mode_o = prot_reg;
    assign secret_mode_o = secret_reg; // RL13
    assign persist_mode_o = persist_reg; // RL14
    assign prog_err_o = perr_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i || por_i);

    sequence s_set_burst(logic [7:0] d);
        cmd_valid_i && cmd_op_i == `BWP_OP_SET_BURST && cmd_data_i[7:0] == d;
    endsequence

    sequence s_corr_rd;
        cmd_valid_i && (cmd_op_i == `BWP_OP_CORR_RD_A ||
                        cmd_op_i == `BWP_OP_CORR_RD_B);
    endsequence

    sequence s_bad_pgm;
        cmd_valid_i && cmd_op_i == `BWP_OP_PROT_PGM &&
        (prot_reg[2:1] != `BWP_PROT_OPEN || cmd_data_i[2:1] == 2'b00);
    endsequence

    chk_wrap_quad_only: assert property ( // RL16
        wrap_active_o |-> $past(quad_read_i || ddr_quad_read_i))
        else $error("wrap active outside quad read");
    chk_wrap_enable_pol: assert property ( // RL1
        (quad_read_i && !burst_cfg_o[4]) ##1 !rst_i |-> wrap_active_o)
        else $error("wrap not active while enabled");
    chk_wrap_span: assert property ( // RL2
        wrap_bytes_o == (7'h08 << burst_cfg_o[1:0]))
        else $error("wrap span mismatch");
    chk_set_burst_wr: assert property ( // RL3
        s_set_burst(cmd_data_i[7:0]) |=>
            burst_cfg_o == ($past(cmd_data_i[7:0]) & 8'hf3))
        else $error("set burst not stored");
    chk_drive_follow: assert property ( // RL4
        cmd_valid_i && cmd_op_i == `BWP_OP_SET_BURST |=>
            drive_strength_o == $past(cmd_data_i[7:5]))
        else $error("drive strength mismatch");
    chk_corr_answer: assert property ( // RL5
        s_corr_rd |=> rsp_valid_o && rsp_data_o[2:0] == $past(corr_flags))
        else $error("correction read answer wrong");
    chk_corr_reset: assert property ( // RL9
        disable iff (por_i)
        rst_i ##1 (s_corr_rd and !rst_i) |=> rsp_data_o == 16'h0000)
        else $error("correction status not zero after reset");
    chk_prot_one_way: assert property ( // RL11
        (prot_mode_o & ~$past(prot_mode_o)) == 16'h0000)
        else $error("protection bit returned to one");
    chk_bad_pgm_err: assert property ( // RL17
        s_bad_pgm |=> prog_err_o && $stable(prot_mode_o))
        else $error("refused program not flagged");
    chk_both_locks: assert property ( // RL18
        !(secret_mode_o && persist_mode_o))
        else $error("both protection modes selected");
    chk_secret_mode: assert property ( // RL13
        secret_mode_o == !prot_mode_o[2])
        else $error("password mode output wrong");
    chk_persist_mode: assert property ( // RL14
        persist_mode_o == !prot_mode_o[1])
        else $error("persistent mode output wrong");
    chk_boot_load: assert property ( // RL15
        disable iff (por_i)
        rst_i |=> burst_cfg_o == ($past(boot_cfg_i) & 8'hf3))
        else $error("burst config not loaded from copy");
    chk_status_bits: assert property ( // RL10
        s_corr_rd |=> rsp_data_o[7:3] == 5'h00)
        else $error("status upper bits not zero");
    chk_status_data: assert property ( // RL7
        corr_upd_i && !cmd_valid_i ##1 (s_corr_rd and
            cmd_addr_i[UNIT_W-1:0] == $past(corr_unit_i)) |=>
            rsp_data_o[1] == $past(corr_flags_i[1], 2))
        else $error("data error flag wrong");
    chk_status_off: assert property ( // RL8
        corr_upd_i && !cmd_valid_i ##1 (s_corr_rd and
            cmd_addr_i[UNIT_W-1:0] == $past(corr_unit_i)) |=>
            rsp_data_o[0] == $past(corr_flags_i[0], 2))
        else $error("correction off flag wrong");

endmodule // bwp_regs_top
`default_nettype wire

//--- design/bwp_regs.svh
// Constants of the burst, correction-status and protection-mode register set.
// Assumes inclusion by the top module and the correction table only.
`ifndef BWP_REGS_SVH
`define BWP_REGS_SVH

// Command opcodes
`define BWP_OP_ANY_RD 8'h65
`define BWP_OP_ANY_WR 8'h71
`define BWP_OP_SET_BURST 8'hc0
`define BWP_OP_CORR_RD_A 8'h18
`define BWP_OP_CORR_RD_B 8'h19
`define BWP_OP_PROT_RD 8'h2b
`define BWP_OP_PROT_PGM 8'h2f

// Register addresses for the any-register commands
`define BWP_ADDR_BURST_CFG 24'h800003
`define BWP_ADDR_PROT_MODE 24'h000030

// Burst configuration fields
`define BWP_CFG_DRIVE_HI 7
`define BWP_CFG_DRIVE_LO 5
`define BWP_CFG_WRAP_DIS 4
`define BWP_CFG_SPAN_HI 1
`define BWP_CFG_SPAN_LO 0
`define BWP_CFG_WR_MASK 8'hf3
`define BWP_WRAP_BASE 7'h08

// Protection mode fields and factory state
`define BWP_PROT_SECRET_LOCK 2
`define BWP_PROT_PERSIST_LOCK 1
`define BWP_PROT_FACTORY 16'hffff
`define BWP_PROT_OPEN 2'b11
`define BWP_PROT_BOTH 2'b00

// Correction status fields and reset value
`define BWP_CORR_CODE_ERR 2
`define BWP_CORR_DATA_ERR 1
`define BWP_CORR_OFF 0
`define BWP_CORR_RESET 3'h0

`endif

//--- design/bwp_pkg.sv
// Types of the burst, correction-status and protection-mode register set.
// Assumes nothing beyond a SystemVerilog compiler.
package bwp_pkg;

    // Decoded class of an incoming register command
    typedef enum logic [2:0] {
        BWP_CMD_NONE = 3'h0,
        BWP_CMD_ANY_RD = 3'h1,
        BWP_CMD_ANY_WR = 3'h2,
        BWP_CMD_SET_BURST = 3'h3,
        BWP_CMD_CORR_RD = 3'h4,
        BWP_CMD_PROT_RD = 3'h5,
        BWP_CMD_PROT_PGM = 3'h6
    } bwp_cmd_t;

endpackage

//--- design/bwp_corr_table.sv
// Per-unit correction status table, written by the array correction engine.
// Assumes updates and reads come synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
`include "bwp_regs.svh"

module bwp_corr_table #(
    parameter int UNITS = 16,
    parameter int UNIT_W = 4
) (
    input wire logic mclk_i,                // System clock
    input wire logic rst_i,                 // Sync reset, high
    input wire logic upd_valid_i,           // Engine status update
    input wire logic [UNIT_W-1:0] upd_unit_i, // Unit being updated
    input wire logic [2:0] upd_flags_i,     // Code err, data err, off
    input wire logic [UNIT_W-1:0] rd_unit_i, // Unit selected by host
    output logic [2:0] rd_flags_o           // Flags of selected unit
);

    logic [2:0] flags_reg [UNITS];

    // ==========================================================
    // Status storage, one entry per unit
    genvar g;
    generate
        for (g = 0; g < UNITS; g++) begin : g_unit
            logic [2:0] flags_next;
            always_comb begin
                flags_next = flags_reg[g];
                if (upd_valid_i && upd_unit_i == UNIT_W'(g)) begin
                    flags_next = upd_flags_i; // RL6 RL7 RL8
                end
            end
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    flags_reg[g] <= `BWP_CORR_RESET; // RL9
                end else begin
                    flags_reg[g] <= flags_next;
                end
            end
        end
    endgenerate

    assign rd_flags_o = flags_reg[rd_unit_i];

endmodule // bwp_corr_table
`default_nettype wire

//--- test/bwp_host_model.sv
// Host side model: frames register commands and collects read answers.
// Assumes answers arrive one cycle after the command edge.
`timescale 1ns/1ps
`default_nettype none
module bwp_host_model (
    input wire logic mclk_i,            // Clock
    input wire logic rsp_valid_i,       // Read answer pulse
    input wire logic [15:0] rsp_data_i, // Read answer data
    output logic cmd_valid_o,           // Command pulse
    output logic [7:0] cmd_op_o,        // Opcode
    output logic [23:0] cmd_addr_o,     // Address or unit
    output logic [15:0] cmd_data_o      // Write data
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_op_o = 8'h00;
        cmd_addr_o = 24'h000000;
        cmd_data_o = 16'h0000;
    end
    // ========================================
    // Command framing
    task automatic send(input logic [7:0] op, input logic [23:0] a,
                        input logic [15:0] d);
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        cmd_op_o <= op;
        cmd_addr_o <= a;
        cmd_data_o <= d;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        // Idle address and data lines do not keep the last value
        cmd_addr_o <= ~a;
        cmd_data_o <= ~d;
    endtask
    task automatic read(input logic [7:0] op, input logic [23:0] a,
                        output logic [15:0] d, output logic v);
        send(op, a, 16'h0000);
        #1;
        v = rsp_valid_i;
        d = rsp_data_i;
    endtask
    task automatic wr_cfg(input logic [7:0] c);
        send(8'h71, 24'h800003, {8'h00, c & 8'hf3});
    endtask
    task automatic rd_status(input logic [7:0] op, input logic [3:0] u,
                             output logic [2:0] f, output logic v);
        logic [15:0] d;
        read(op, {20'h00000, u}, d, v);
        f = d[2:0];
    endtask
endmodule // bwp_host_model
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench of the burst, correction and protection registers.
// Assumes bwp_regs_top and bwp_host_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk_i, rst_i, por_i, quad_read_i, ddr_quad_read_i;
    logic corr_upd_i, prog_err_clr_i, cmd_valid_i, rsp_valid_o;
    logic [7:0] boot_cfg_i, cmd_op_i, burst_cfg_o;
    logic [23:0] cmd_addr_i;
    logic [15:0] cmd_data_i, rsp_data_o, prot_mode_o, d;
    logic [3:0] corr_unit_i;
    logic [2:0] corr_flags_i, drive_strength_o, f;
    logic [6:0] wrap_bytes_o;
    logic wrap_active_o, secret_mode_o, persist_mode_o, prog_err_o, v;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    bwp_regs_top #(.UNITS(16), .UNIT_W(4)) DUT (
        .mclk_i(mclk_i), .rst_i(rst_i), .por_i(por_i),
        .boot_cfg_i(boot_cfg_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
        .cmd_data_i(cmd_data_i), .quad_read_i(quad_read_i),
        .ddr_quad_read_i(ddr_quad_read_i), .corr_upd_i(corr_upd_i),
        .corr_unit_i(corr_unit_i), .corr_flags_i(corr_flags_i),
        .prog_err_clr_i(prog_err_clr_i), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o), .burst_cfg_o(burst_cfg_o),
        .drive_strength_o(drive_strength_o),
        .wrap_active_o(wrap_active_o), .wrap_bytes_o(wrap_bytes_o),
        .prot_mode_o(prot_mode_o), .secret_mode_o(secret_mode_o),
        .persist_mode_o(persist_mode_o), .prog_err_o(prog_err_o));

    bwp_host_model host (
        .mclk_i(mclk_i), .rsp_valid_i(rsp_valid_o),
        .rsp_data_i(rsp_data_o), .cmd_valid_o(cmd_valid_i),
        .cmd_op_o(cmd_op_i), .cmd_addr_o(cmd_addr_i),
        .cmd_data_o(cmd_data_i));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    // ========================================
    // Checking and closing
    task automatic chk(input logic [15:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end
    // ========================================
    // Helpers
    task automatic do_reset(input logic [7:0] b);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        por_i <= 1'b1;
        boot_cfg_i <= b;
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        #1;
    endtask
    task automatic wrap_case(input logic [7:0] c, input logic q, dq, e);
        host.wr_cfg(c);
        quad_read_i <= q;
        ddr_quad_read_i <= dq;
        repeat (2) @(posedge mclk_i);
        #1;
        chk({15'h0000, wrap_active_o}, {15'h0000, e}, "wrap");
    endtask
    task automatic prot_cmd(input logic [7:0] op, input logic [23:0] a,
                            input logic [15:0] w, exp, input logic err);
        host.send(op, a, w);
        #1;
        chk(prot_mode_o, exp, "prot");
        chk({15'h0000, prog_err_o}, {15'h0000, err}, "perr");
    endtask
    // ========================================
    // Tests
    initial begin
        rst_i = 1'b1;
        por_i = 1'b1;
        boot_cfg_i = 8'hff;
        quad_read_i = 1'b0;
        ddr_quad_read_i = 1'b0;
        corr_upd_i = 1'b0;
        corr_unit_i = 4'h0;
        corr_flags_i = 3'h0;
        prog_err_clr_i = 1'b0;
        do_reset(8'hff);
        chk({8'h00, burst_cfg_o}, 16'h00f3, "boot cfg");
        chk(prot_mode_o, 16'hffff, "prot init");
        host.read(8'h2b, 24'h000000, d, v);
        chk(d, 16'hffff, "prot rd");
        $display("test reset done");
        for (int s = 0; s < 4; s++) begin
            host.send(8'hc0, 24'h0, {8'h00, 3'(s + 3), 1'b0, 2'h0, 2'(s)});
            #1;
            chk({9'h000, wrap_bytes_o}, 16'(8 << s), "span");
            chk({13'h0, drive_strength_o}, 16'(s + 3), "drive");
        end
        host.wr_cfg(8'hef);
        host.read(8'h65, 24'h800003, d, v);
        chk(d, 16'h00e3, "cfg rd");
        host.read(8'h65, 24'h123456, d, v);
        chk({15'h0000, v}, 16'h0001, "unmapped valid");
        chk(d, 16'h0000, "unmapped");
        wrap_case(8'he3, 1'b1, 1'b0, 1'b1);
        wrap_case(8'he3, 1'b0, 1'b1, 1'b1);
        wrap_case(8'he3, 1'b0, 1'b0, 1'b0);
        wrap_case(8'hf3, 1'b1, 1'b1, 1'b0);
        $display("test burst done");
        for (int u = 0; u < 8; u++) begin
            @(posedge mclk_i);
            corr_upd_i <= 1'b1;
            corr_unit_i <= 4'(2 * u + 1);
            corr_flags_i <= 3'(u);
        end
        @(posedge mclk_i);
        corr_upd_i <= 1'b0;
        for (int u = 0; u < 8; u++) begin
            host.rd_status(u[0] ? 8'h19 : 8'h18, 4'(2 * u + 1), f, v);
            chk({13'h0, f}, 16'(u), "status");
            chk({15'h0000, v}, 16'h0001, "status valid");
            host.rd_status(8'h18, 4'(2 * u), f, v);
            chk({13'h0, f}, 16'h0000, "status idle");
        end
        // Update one unit and read it back on the very next command
        @(posedge mclk_i);
        corr_upd_i <= 1'b1;
        corr_unit_i <= 4'h2;
        corr_flags_i <= 3'h6;
        host.rd_status(8'h19, 4'h2, f, v);
        chk({13'h0, f}, 16'h0006, "status fresh");
        @(posedge mclk_i);
        corr_upd_i <= 1'b0;
        $display("test status done");
        prot_cmd(8'h2f, 24'h0, 16'hfff9, 16'hffff, 1'b1);
        @(posedge mclk_i);
        prog_err_clr_i <= 1'b1;
        @(posedge mclk_i);
        prog_err_clr_i <= 1'b0;
        prot_cmd(8'h71, 24'h000030, 16'hfffb, 16'hfffb, 1'b0);
        chk({14'h0, secret_mode_o, persist_mode_o}, 16'h0002, "m");
        host.read(8'h65, 24'h000030, d, v);
        chk(d, 16'hfffb, "prot any rd");
        prot_cmd(8'h2f, 24'h0, 16'hfffd, 16'hfffb, 1'b1);
        // Hardware reset alone, with a status read at the first free edge
        @(posedge mclk_i);
        rst_i <= 1'b1;
        boot_cfg_i <= 8'h2d;
        repeat (3) @(posedge mclk_i);
        fork
            host.rd_status(8'h18, 4'hf, f, v);
            begin
                @(posedge mclk_i);
                rst_i <= 1'b0;
            end
        join
        chk({13'h0, f}, 16'h0000, "status after reset");
        chk({8'h00, burst_cfg_o}, 16'h0021, "hw reload");
        chk(prot_mode_o, 16'hfffb, "prot kept");
        chk({15'h0000, prog_err_o}, 16'h0000, "perr reset");
        do_reset(8'h5a);
        chk({8'h00, burst_cfg_o}, 16'h0052, "reload");
        prot_cmd(8'h2f, 24'h0, 16'hfffd, 16'hfffd, 1'b0);
        chk({14'h0, secret_mode_o, persist_mode_o}, 16'h0001, "m");
        $display("test protection done");
        final_report();
    end
endmodule // tb_top
`default_nettype wire
